// ===== sim/pecirq_pins_model.sv
// port pin model standing in for the outside world
`timescale 1ns/1ps
module pecirq_pins_model (
    input wire logic clock,
    input wire logic [39:0] want,
    output logic [39:0] pins
);
    // pins move to the commanded level right after an edge
    initial pins = 40'h0;
    always @(posedge clock) begin
        pins <= want;
    end
endmodule

// ===== sim/pin_edge_change_interrupt_bench.sv
// self-checking bench for the pin edge change unit
`timescale 1ns/1ps
module pin_edge_change_interrupt_bench;
    import pecirq_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [39:0] want = 40'h0;
    logic [39:0] pins;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic irq, wake, change_irq_summary, en;
    logic [7:0] d, r, f, w;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int p;
    int rise [5], fall [5], flg [5];
    // clock and units under test
    always #2.5 clock = ~clock;
    pecirq_top pecirq_top_i (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .pins(pins), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .irq(irq), .wake(wake), .change_irq_summary(change_irq_summary));
    pecirq_pins_model pecirq_pins_model_i (.clock(clock), .want(want), .pins(pins));
    // implemented bits of a port
    function automatic int msk(int q);
        return q == 4 ? 8'h08 : 8'hff;
    endfunction
    function automatic logic anyf();
        return (flg[0] | flg[1] | flg[2] | flg[3] | flg[4]) != 0;
    endfunction
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one-cycle register strobes
    task automatic wreg(logic [7:0] a, logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rreg(logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(posedge clock);
        v = rdata;
    endtask
    task automatic summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            failures++;
            summarize();
        end
    end
    // main sequence
    initial begin
        void'($urandom(32'h04a02040));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 28; i++) begin
            rreg(8'(i), d);
            chk("reset value", 8'h00, d);
        end
        $display("test reset done");
        for (int t = 0; t < 40; t++) begin
            p = $urandom % 5;
            if (t % 4 == 0) begin
                en = (t % 8 == 0);
                wreg(CTRL_ADDR, {7'h00, en});
            end
            r = $urandom;
            f = $urandom;
            w = $urandom;
            wreg(RISE_BASE + 8'(p), r);
            wreg(FALL_BASE + 8'(p), f);
            rise[p] = r & msk(p);
            fall[p] = f & msk(p);
            // armed edges set flags, unarmed ones do not
            flg[p] |= (~want[8*p+:8] & w & rise[p] | want[8*p+:8] & ~w & fall[p]) & msk(p);
            want[8*p+:8] <= w;
            repeat (8) @(posedge clock);
            rreg(RISE_BASE + 8'(p), d);
            chk("rise_enable", rise[p], d);
            rreg(FALL_BASE + 8'(p), d);
            chk("fall_enable", fall[p], d);
            rreg(FLAG_BASE + 8'(p), f);
            chk("change_flag", flg[p], f);
            rreg(CTRL_ADDR, d);
            chk("irq control", {6'h00, anyf(), en}, d);
            chk("summary", 8'(anyf()), 8'(change_irq_summary));
            chk("irq", 8'(anyf() & en), 8'(irq));
            chk("wake", 8'(anyf() & en), 8'(wake));
            if (t % 2) begin
                wreg(FLAG_BASE + 8'(p), ~f);
                flg[p] &= ~f;
            end
        end
        $display("test edges done");
        rreg(IRQ_STAT_ADDR, d);
        chk("change event", 8'h01, d & 8'h01);
        wreg(CTRL_ADDR, 8'h00);
        wreg(IRQ_MASK_ADDR, 8'h01);
        repeat (2) @(posedge clock);
        chk("masked irq", 8'h01, 8'(irq));
        wreg(IRQ_STAT_ADDR, 8'h03);
        repeat (2) @(posedge clock);
        chk("cleared irq", 8'h00, 8'(irq));
        $display("test status done");
        // edge landing in the same cycle as a flag clear on port 1
        wreg(RISE_BASE + 8'h01, 8'hff);
        wreg(FALL_BASE + 8'h01, 8'hff);
        repeat (6) @(posedge clock);
        wreg(FLAG_BASE + 8'h01, 8'h00);
        want[15:8] <= ~want[15:8];
        repeat (3) @(posedge clock);
        addr <= FLAG_BASE + 8'h01;
        wdata <= 8'h00;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        rreg(FLAG_BASE + 8'h01, d);
        chk("set during clear", 8'hff, d);
        $display("test clear race done");
        // pin change while frozen is seen only after the enable returns
        wreg(RISE_BASE, 8'hff);
        want[7:0] <= 8'h00;
        repeat (6) @(posedge clock);
        for (int i = 0; i < 5; i++) begin
            wreg(FLAG_BASE + 8'(i), 8'h00);
        end
        clk_en <= 1'b0;
        want[7:0] <= 8'hff;
        repeat (8) @(posedge clock);
        chk("frozen summary", 8'h00, 8'(change_irq_summary));
        clk_en <= 1'b1;
        repeat (6) @(posedge clock);
        rreg(FLAG_BASE, d);
        chk("flag after freeze", 8'hff, d);
        // reset in mid-run clears flags and enables
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        chk("irq after reset", 8'h00, 8'(irq));
        rreg(FLAG_BASE, d);
        chk("flag after reset", 8'h00, d);
        rreg(RISE_BASE, d);
        chk("rise after reset", 8'h00, d);
        $display("test freeze and reset done");
        summarize();
    end
endmodule

// ===== verilog/pecirq_pkg.sv
// package for the pin edge change interrupt block
package pecirq_pkg;
    // ports: a, b, c, d (8 bits each), e (bit 3 only)
    localparam int NUM_PORTS = 5;
    localparam int PORT_W = 8;
    localparam logic [7:0] PORT5_MASK = 8'h08;
    localparam logic [7:0] FULL_MASK = 8'hff;
    localparam logic [7:0] REG_RESET = 8'h00;
    // register index layout: port p at base + p
    localparam logic [7:0] RISE_BASE = 8'h00;
    localparam logic [7:0] FALL_BASE = 8'h08;
    localparam logic [7:0] FLAG_BASE = 8'h10;
    localparam logic [7:0] CTRL_ADDR = 8'h18;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h19;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h1a;
    // control register fields
    localparam int CTRL_IRQ_EN_BIT = 0;
    localparam int CTRL_SUMMARY_BIT = 1;
    // local status bits
    localparam int ST_CHANGE_BIT = 0;
    localparam int ST_WAKE_BIT = 1;
    localparam int ST_W = 2;
    localparam logic [1:0] ST_RESET = 2'h0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pecirq_bus_s;

    typedef struct packed {
        logic [NUM_PORTS-1:0][PORT_W-1:0] s1;
        logic [NUM_PORTS-1:0][PORT_W-1:0] s2;
        logic [NUM_PORTS-1:0][PORT_W-1:0] s3;
        logic [NUM_PORTS-1:0][PORT_W-1:0] rise;
        logic [NUM_PORTS-1:0][PORT_W-1:0] fall;
        logic [NUM_PORTS-1:0][PORT_W-1:0] flag;
        logic irq_en;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        logic [7:0] rdata;
        logic irq;
        logic wake;
        logic summary;
    } pecirq_state_s;
endpackage

// ===== verilog/pecirq_top.sv
// pin edge change interrupt unit with register port
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) each pin's rising detector works only while its rise_enable bit is set.
// (RULE_02) each pin's falling detector works only while its fall_enable bit is set.
// (RULE_03) with both enables set a pin responds to edges in both directions.
// (RULE_04) an armed edge sets the pin's change_flag bit, which holds until software clears it.
// (RULE_05) the change request rises only when a flag is set and change_irq_enable is set; the code also raises irq for any unmasked stat bit.
// (RULE_06) change_irq_summary is read only and is the or of all implemented flag bits.
// (RULE_07) writing zero to a change_flag bit clears it.
// (RULE_08) an armed edge arriving during a flag write sets the flag whatever is written.
// (RULE_09) software should clear flags with an and-mask of the bits it saw set.
// (RULE_10) with change_irq_enable set a detected change wakes the core from sleep.
// (RULE_11) an edge seen in sleep is in its flag before the first instruction after wake.
// (RULE_12) enable and flag registers hold bits 7-0 and reset to zero.
// (RULE_13) a cleared enable bit stops detection for that pin and direction.
// (RULE_14) the fifth port implements only bit 3; other bits read zero.
// (RULE_15) a flag reads zero until an armed change, then one.
// (RULE_16) edges are still detected and flagged while change_irq_enable is clear.
// (RULE_17) each pin is synchronised and compared with its previous sample for edges.
module pecirq_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [pecirq_pkg::NUM_PORTS*pecirq_pkg::PORT_W-1:0] pins,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    output logic wake,
    output logic change_irq_summary
);
    import pecirq_pkg::*;

    pecirq_state_s q;
    pecirq_state_s d;
    pecirq_bus_s bus;

    // implemented bits of a port
    function automatic logic [7:0] port_mask(input int p);
        return (p == NUM_PORTS - 1) ? PORT5_MASK : FULL_MASK;
    endfunction

    // match an address to a per-port register, returns port index or -1
    function automatic int port_hit(input logic [7:0] a, input logic [7:0] base);
        int r;
        r = -1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (a == 8'(base + 8'(p))) begin
                r = p;
            end
        end
        return r;
    endfunction

    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // next state: sync, detect, flags, register access
    always_comb begin
        logic [NUM_PORTS-1:0][PORT_W-1:0] rise_ev;
        logic [NUM_PORTS-1:0][PORT_W-1:0] fall_ev;
        logic [NUM_PORTS-1:0][PORT_W-1:0] hit;
        logic any_flag;
        logic any_hit;
        logic [ST_W-1:0] ev;
        int pr;
        int pf;
        int pg;
        rise_ev = '0;
        fall_ev = '0;
        hit = '0;
        any_flag = 1'b0;
        any_hit = 1'b0;
        ev = '0;
        pr = port_hit(bus.addr, RISE_BASE);
        pf = port_hit(bus.addr, FALL_BASE);
        pg = port_hit(bus.addr, FLAG_BASE);
        d = q;
        d.rdata = 8'h00;
        // three stage synchroniser; edges compare stages two and three
        d.s1 = pins; // RULE_17
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int p = 0; p < NUM_PORTS; p++) begin
            rise_ev[p] = q.s2[p] & ~q.s3[p] & q.rise[p]; // RULE_01 RULE_13 RULE_17
            fall_ev[p] = ~q.s2[p] & q.s3[p] & q.fall[p]; // RULE_02 RULE_13
            hit[p] = (rise_ev[p] | fall_ev[p]) & port_mask(p); // RULE_03 RULE_14
        end
        // register writes
        if (bus.wr) begin
            if (pr >= 0) begin
                d.rise[pr] = bus.wdata & port_mask(pr); // RULE_14
            end else if (pf >= 0) begin
                d.fall[pf] = bus.wdata & port_mask(pf);
            end else if (pg >= 0) begin
                d.flag[pg] = q.flag[pg] & bus.wdata; // RULE_07 RULE_09
            end else if (bus.addr == CTRL_ADDR) begin
                d.irq_en = bus.wdata[CTRL_IRQ_EN_BIT];
            end else if (bus.addr == IRQ_STAT_ADDR) begin
                d.stat = q.stat & ~bus.wdata[ST_W-1:0];
            end else if (bus.addr == IRQ_MASK_ADDR) begin
                d.mask = bus.wdata[ST_W-1:0];
            end
        end
        // hardware set wins over any write, flagging continues with enable low
        for (int p = 0; p < NUM_PORTS; p++) begin
            d.flag[p] = d.flag[p] | hit[p]; // RULE_04 RULE_08 RULE_11 RULE_15 RULE_16
            any_hit = any_hit | (|hit[p]);
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
            any_flag = any_flag | (|(d.flag[p] & port_mask(p))); // RULE_06
        end
        d.summary = any_flag;
        // local sticky events
        ev[ST_CHANGE_BIT] = any_hit;
        ev[ST_WAKE_BIT] = any_hit & q.irq_en;
        d.stat = d.stat | ev;
        d.irq = (any_flag & d.irq_en) | (|(d.stat & d.mask)); // RULE_05
        d.wake = any_flag & d.irq_en; // RULE_10
        // register reads, unmapped answers zero
        if (bus.rd) begin
            if (pr >= 0) begin
                d.rdata = q.rise[pr];
            end else if (pf >= 0) begin
                d.rdata = q.fall[pf];
            end else if (pg >= 0) begin
                d.rdata = q.flag[pg] & port_mask(pg); // RULE_15
            end else if (bus.addr == CTRL_ADDR) begin
                d.rdata = {6'h00, q.summary, q.irq_en}; // RULE_06
            end else if (bus.addr == IRQ_STAT_ADDR) begin
                d.rdata = {6'h00, q.stat};
            end else if (bus.addr == IRQ_MASK_ADDR) begin
                d.rdata = {6'h00, q.mask};
            end
        end
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0; // RULE_12
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign irq = q.irq;
    assign wake = q.wake;
    assign change_irq_summary = q.summary;

    // flag set by an armed rising edge whatever the write
    flag_set_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
        clk_en && q.rise[0][0] && q.s2[0][0] && !q.s3[0][0] |=> q.flag[0][0])
        else $error("armed rising edge did not set flag");

    // no flag without an armed edge or when cleared
    flag_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
        clk_en && !q.flag[0][0] && !(q.rise[0][0] || q.fall[0][0]) |=> !q.flag[0][0])
        else $error("flag set on unarmed pin");

    // falling edge detection
    fall_set_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
        clk_en && q.fall[1][2] && !q.s2[1][2] && q.s3[1][2] |=> q.flag[1][2])
        else $error("armed falling edge did not set flag");

    // write of zero clears a flag with no edge
    flag_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
        clk_en && wr && addr == FLAG_BASE && wdata == 8'h00 && q.s2[0] == q.s3[0]
        |=> q.flag[0] == 8'h00)
        else $error("flag write of zero did not clear");

    // request gated by the enable
    irq_gate_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
        clk_en && !d.irq_en && d.mask == '0 |=> !irq)
        else $error("request raised with enable clear");

    // summary follows the flags
    summary_or_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
        change_irq_summary == (|q.flag))
        else $error("summary does not match flags");

    // fifth port keeps only bit 3
    port5_bits_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
        (q.flag[NUM_PORTS-1] & ~PORT5_MASK) == 8'h00
        && (q.rise[NUM_PORTS-1] & ~PORT5_MASK) == 8'h00)
        else $error("unimplemented fifth port bit set");

    // wake with enable and pending flag
    wake_out_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
        wake |-> change_irq_summary && q.irq_en)
        else $error("wake without enabled pending change");

    // both directions armed: a change either way sets the flag
    both_edges_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
        clk_en && q.rise[2][5] && q.fall[2][5] && q.s2[2][5] != q.s3[2][5]
        |=> q.flag[2][5])
        else $error("dual armed pin missed an edge");

    // both directions armed: a falling edge on another port
    both_fall_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_03
        clk_en && q.rise[3][0] && q.fall[3][0] && !q.s2[3][0] && q.s3[3][0]
        |=> q.flag[3][0])
        else $error("dual armed pin missed a falling edge");

    // rising detector on a high bit of port four
    rise_port3_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
        clk_en && q.rise[3][7] && q.s2[3][7] && !q.s3[3][7] |=> q.flag[3][7])
        else $error("armed rising edge on port four missed");

    // rising detector on the single bit of the fifth port
    rise_port5_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
        clk_en && q.rise[4][3] && q.s2[4][3] && !q.s3[4][3] |=> q.flag[4][3])
        else $error("armed rising edge on fifth port missed");

    // falling detector on the single bit of the fifth port
    fall_port5_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
        clk_en && q.fall[4][3] && !q.s2[4][3] && q.s3[4][3] |=> q.flag[4][3])
        else $error("armed falling edge on fifth port missed");

    // falling detector on a high bit of port two
    fall_port1_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
        clk_en && q.fall[1][5] && !q.s2[1][5] && q.s3[1][5] |=> q.flag[1][5])
        else $error("armed falling edge on port two missed");

    // a falling edge without its enable leaves the flag clear
    fall_unarmed_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
        clk_en && !q.fall[0][0] && !q.flag[0][0] && !q.s2[0][0] && q.s3[0][0]
        |=> !q.flag[0][0])
        else $error("unarmed falling edge set flag");

    // a rising edge without its enable leaves the flag clear
    rise_unarmed_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_13
        clk_en && !q.rise[1][6] && !q.flag[1][6] && q.s2[1][6] && !q.s3[1][6]
        |=> !q.flag[1][6])
        else $error("unarmed rising edge set flag");

    // a set flag holds while nobody writes its register
    flag_sticky_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
        clk_en && q.flag[0][0] && !(wr && addr == FLAG_BASE) |=> q.flag[0][0])
        else $error("flag dropped without a write");

    // a high flag bit of port four also holds on its own
    flag_sticky_hi_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_15
        clk_en && q.flag[3][7] && !(wr && addr == FLAG_BASE + 8'h03) |=> q.flag[3][7])
        else $error("flag of port four dropped without a write");

    // pending change with the enable set raises the request
    irq_on_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
        clk_en && d.irq_en && d.summary |=> irq)
        else $error("enabled pending change gave no request");

    // the request always has a cause
    irq_cause_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
        irq |-> (change_irq_summary && q.irq_en) || (|(q.stat & q.mask)))
        else $error("request without a cause");

    // an unmasked sticky status bit raises the request
    stat_irq_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_05
        clk_en && |(d.stat & d.mask) |=> irq)
        else $error("unmasked status gave no request");

    // flagging goes on with the request enable low
    flag_no_en_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_16
        clk_en && !q.irq_en && q.rise[1][0] && q.s2[1][0] && !q.s3[1][0]
        |=> q.flag[1][0])
        else $error("edge not flagged with enable clear");

    // pending change with the enable set wakes the core
    wake_on_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
        clk_en && d.irq_en && d.summary |=> wake)
        else $error("enabled pending change did not wake");

    // no wake with the enable clear
    wake_off_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_10
        clk_en && !d.irq_en |=> !wake)
        else $error("wake with enable clear");

    // the flag is already visible when wake rises
    wake_flag_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
        $rose(wake) |-> change_irq_summary)
        else $error("wake rose before its flag");

    // wake always points at a recorded flag
    wake_cause_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_11
        wake |-> |q.flag)
        else $error("wake without a recorded flag");

    // writing zero clears the flags of port three when quiet
    clear_port2_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
        clk_en && wr && addr == FLAG_BASE + 8'h02 && wdata == 8'h00 && q.s2[2] == q.s3[2]
        |=> q.flag[2] == 8'h00)
        else $error("flag write of zero on port three did not clear");

    // writing zero clears the fifth port flag when quiet
    clear_port4_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_07
        clk_en && wr && addr == FLAG_BASE + 8'h04 && wdata == 8'h00 && q.s2[4] == q.s3[4]
        |=> q.flag[4] == 8'h00)
        else $error("flag write of zero on fifth port did not clear");

    // an armed rising edge beats a clearing write
    set_wins_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
        clk_en && wr && addr == FLAG_BASE && wdata == 8'h00
        && q.rise[0][3] && q.s2[0][3] && !q.s3[0][3] |=> q.flag[0][3])
        else $error("clearing write lost a rising edge");

    // an armed falling edge beats a clearing write
    set_wins_fall_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_08
        clk_en && wr && addr == FLAG_BASE + 8'h01 && wdata == 8'h00
        && q.fall[1][1] && !q.s2[1][1] && q.s3[1][1] |=> q.flag[1][1])
        else $error("clearing write lost a falling edge");

    // reading a flag register returns the flags
    read_flag_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_15
        clk_en && rd && addr == FLAG_BASE |=> rdata == $past(q.flag[0]))
        else $error("flag read returned wrong data");

    // reading a rising enable register returns it
    read_rise_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_01
        clk_en && rd && addr == RISE_BASE + 8'h01 |=> rdata == $past(q.rise[1]))
        else $error("rising enable read returned wrong data");

    // reading a falling enable register returns it
    read_fall_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_02
        clk_en && rd && addr == FALL_BASE + 8'h02 |=> rdata == $past(q.fall[2]))
        else $error("falling enable read returned wrong data");

    // fifth port reads zero outside bit 3
    read_port5_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
        clk_en && rd && addr == FLAG_BASE + 8'h04 |=> (rdata & ~PORT5_MASK) == 8'h00)
        else $error("fifth port read shows unimplemented bits");

    // fifth port falling enable keeps only bit 3
    port5_fall_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_14
        (q.fall[NUM_PORTS-1] & ~PORT5_MASK) == 8'h00)
        else $error("unimplemented fifth port fall bit set");

    // control read shows summary and enable
    read_ctrl_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_06
        clk_en && rd && addr == CTRL_ADDR
        |=> rdata[CTRL_SUMMARY_BIT] == $past(q.summary)
        && rdata[CTRL_IRQ_EN_BIT] == $past(q.irq_en))
        else $error("control read returned wrong data");

    // read data stand only in the cycle after a read
    rdata_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_15
        clk_en && !rd |=> rdata == 8'h00)
        else $error("read data without a read");

    // synchroniser stages shift one per enabled clock
    sync_shift_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_17
        clk_en |=> q.s3 == $past(q.s2) && q.s2 == $past(q.s1))
        else $error("synchroniser did not shift");

    // low clock enable freezes all state
    freeze_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_17
        !clk_en |=> $stable(q))
        else $error("state moved while frozen");

    // enables and flags start cleared after reset
    reset_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_12
        $rose(rst_n) |-> q.flag == '0 && q.rise == '0 && q.fall == '0)
        else $error("registers not cleared by reset");

    // the change event status bit is sticky until written
    stat_sticky_a: assert property (@(posedge clock) disable iff (!rst_n) // RULE_04
        clk_en && q.stat[ST_CHANGE_BIT] && !(wr && addr == IRQ_STAT_ADDR)
        |=> q.stat[ST_CHANGE_BIT])
        else $error("change event dropped without a write");
endmodule
